/* core/jts_pkg.sv */
// Purpose: Shared constants and types for the TAP selection block
// Assumes: One 250 MHz clock, synchronous active-low reset
// Notes: Pad mux mode codes are four bits wide
package jts_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int CLK_MHZ = 250;
	localparam int TRST_LOW_MIN_NS = 100;
	localparam int TRST_LOW_CYC = (TRST_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int LOW_CNT_W = 6;
	localparam int SYNC_STAGES = 2;
	localparam int SYNC_W = 3;

	// ************************************************************
	// Synchroniser bit positions
	// ************************************************************
	localparam int SYNC_TRST = 0;
	localparam int SYNC_EMULATION_PIN_ZERO = 1;
	localparam int SYNC_EMULATION_PIN_ONE = 2;

	// ************************************************************
	// Pad mux modes and emulation pair codes
	// ************************************************************
	localparam int MODE_W = 4;
	localparam logic [MODE_W-1:0] MODE_DEFAULT = 4'h0;
	localparam logic [MODE_W-1:0] MODE_ZERO_KEEP = 4'hf;
	localparam logic [MODE_W-1:0] MODE_OBS_EMULATION_PIN_ONE = 4'h1;
	localparam logic [MODE_W-1:0] MODE_OBS_SPI = 4'h1;
	localparam logic [1:0] PAIR_BSCAN = 2'h1;
	localparam logic [1:0] PAIR_SAFE = 2'h0;
	localparam logic [1:0] PAIR_RESET = 2'h0;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic {
		JTS_TAP_DEBUG = 1'b0,
		JTS_TAP_BSCAN = 1'b1
	} jts_tap_e;

	typedef struct packed {
		logic [MODE_W-1:0] emuPinZeroPadConfig;
		logic [MODE_W-1:0] emuPinOnePadConfig;
		logic [MODE_W-1:0] spiCs1PadConfig;
	} jts_pad_cfg_s;

	typedef struct packed {
		logic emuOneOut;
		logic emuOneOeN;
		logic spiCs1Out;
		logic spiCs1OeN;
	} jts_pad_drv_s;

endpackage

/* core/jts_pad_mux.sv */
// Purpose: Pad multiplexing for the emulation and chip-select pads
// Assumes: Pad inputs arrive already synchronised
// Notes: Purely combinational
module jts_pad_mux (
	input wire logic pinZero,
	input wire logic pinOne,
	input wire jts_pkg::jts_pad_cfg_s padCfg,
	input wire logic observationClockOutput,
	input wire logic spiChipSelectFn,
	output logic [1:0] emuPair,
	output jts_pkg::jts_pad_drv_s padDrv
);
	import jts_pkg::*;

	logic zeroFollows;
	logic oneFollows;

	// ************************************************************
	// Internal emulation pair
	// ************************************************************
	always_comb begin
		zeroFollows = (padCfg.emuPinZeroPadConfig == MODE_DEFAULT) ||
			(padCfg.emuPinZeroPadConfig == MODE_ZERO_KEEP);
		oneFollows = padCfg.emuPinOnePadConfig == MODE_DEFAULT;
		if (!zeroFollows) begin
			emuPair = PAIR_SAFE;
		end else begin
			emuPair[0] = pinZero;
			emuPair[1] = oneFollows ? pinOne : 1'b0;
		end
	end

	// ************************************************************
	// Pad output drive
	// ************************************************************
	always_comb begin
		padDrv.emuOneOut = 1'b0;
		padDrv.emuOneOeN = 1'b1;
		padDrv.spiCs1Out = 1'b1;
		padDrv.spiCs1OeN = 1'b1;
		if (padCfg.emuPinOnePadConfig == MODE_OBS_EMULATION_PIN_ONE) begin
			padDrv.emuOneOut = observationClockOutput;
			padDrv.emuOneOeN = 1'b0;
		end
		if (padCfg.spiCs1PadConfig == MODE_OBS_SPI) begin
			padDrv.spiCs1Out = observationClockOutput;
			padDrv.spiCs1OeN = 1'b0;
		end else if (padCfg.spiCs1PadConfig == MODE_DEFAULT) begin
			padDrv.spiCs1Out = spiChipSelectFn;
			padDrv.spiCs1OeN = 1'b0;
		end
	end

endmodule

/* core/jts_tap_select.sv */
// Purpose: Chooses the TAP behind the JTAG port at test reset release
// Assumes: Test reset and emulation pads are asynchronous pins
// Notes: Selection changes only on a test reset rising edge
module jts_tap_select (
	input wire logic clk,
	input wire logic nrst,
	input wire logic testResetN,
	input wire logic emulationPinZero,
	input wire logic emulationPinOne,
	input wire jts_pkg::jts_pad_cfg_s padCfg,
	input wire logic observationClockOutput,
	input wire logic spiChipSelectFn,
	output jts_pkg::jts_tap_e tapSelect,
	output logic boundaryScanSel,
	output logic debugTapSel,
	output logic debugChainReady,
	output logic [1:0] sampledPair,
	output logic emuOnePadOut,
	output logic emuOnePadOeN,
	output logic spiCs1PadOut,
	output logic spiCs1PadOeN
);
	import jts_pkg::*;

	logic [SYNC_W-1:0] syncFirst;
	logic [SYNC_W-1:0] syncSecond;
	logic trstPrev;
	logic trstRise;
	logic trstLevel;
	logic [1:0] emuPair;
	jts_pad_drv_s padDrv;
	logic [LOW_CNT_W-1:0] lowCnt;
	logic [LOW_CNT_W-1:0] next_lowCnt;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : gSync
			always_ff @(posedge clk) begin
				if (!nrst) begin
					syncFirst[gi] <= 1'b0;
					syncSecond[gi] <= 1'b0;
				end else begin
					syncFirst[gi] <= gi == SYNC_TRST ? testResetN :
						gi == SYNC_EMULATION_PIN_ZERO ? emulationPinZero : emulationPinOne;
					syncSecond[gi] <= syncFirst[gi];
				end
			end
		end
	endgenerate

	assign trstLevel = syncSecond[SYNC_TRST];

	// ************************************************************
	// Test reset edge detect
	// ************************************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			trstPrev <= 1'b0;
		end else begin
			trstPrev <= trstLevel;
		end
	end

	// Release by the debugger is the sampling moment
	assign trstRise = trstLevel && !trstPrev;

	// ************************************************************
	// Pad multiplexing
	// ************************************************************
	jts_pad_mux uMux (
		.pinZero(syncSecond[SYNC_EMULATION_PIN_ZERO]),
		.pinOne(syncSecond[SYNC_EMULATION_PIN_ONE]),
		.padCfg(padCfg),
		.observationClockOutput(observationClockOutput),
		.spiChipSelectFn(spiChipSelectFn),
		.emuPair(emuPair),
		.padDrv(padDrv)
	);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			emuOnePadOut <= 1'b0;
			emuOnePadOeN <= 1'b1;
			spiCs1PadOut <= 1'b1;
			spiCs1PadOeN <= 1'b1;
		end else begin
			emuOnePadOut <= padDrv.emuOneOut;
			emuOnePadOeN <= padDrv.emuOneOeN;
			spiCs1PadOut <= padDrv.spiCs1Out;
			spiCs1PadOeN <= padDrv.spiCs1OeN;
		end
	end

	emu_one_low_a: assert property (@(posedge clk)
		disable iff (!nrst)
		padCfg.emuPinOnePadConfig != MODE_DEFAULT |-> !emuPair[1])
		else $error("emulation pin one not low outside mode 0");

	emu_zero_follow_a: assert property (@(posedge clk)
		disable iff (!nrst)
		padCfg.emuPinZeroPadConfig == MODE_DEFAULT |->
		emuPair[0] == syncSecond[SYNC_EMULATION_PIN_ZERO])
		else $error("emulation pin zero does not follow pad");

	safe_pair_a: assert property (@(posedge clk)
		disable iff (!nrst)
		padCfg.emuPinZeroPadConfig != MODE_DEFAULT &&
		padCfg.emuPinZeroPadConfig != MODE_ZERO_KEEP |->
		emuPair == PAIR_SAFE)
		else $error("emulation pair not forced to 00b");

	obs_on_spi_a: assert property (@(posedge clk)
		disable iff (!nrst)
		padCfg.spiCs1PadConfig == MODE_OBS_SPI |=>
		spiCs1PadOut == $past(observationClockOutput) && !spiCs1PadOeN)
		else $error("observation clock missing on chip-select pad");

	// ************************************************************
	// TAP selection latch
	// ************************************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sampledPair <= PAIR_RESET;
		end else if (trstRise) begin
			sampledPair <= emuPair;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			tapSelect <= JTS_TAP_DEBUG;
		end else if (trstRise) begin
			if (emuPair == PAIR_BSCAN) begin
				tapSelect <= JTS_TAP_BSCAN;
			end else begin
				tapSelect <= JTS_TAP_DEBUG;
			end
		end
	end

	// Exactly one TAP is routed to the port
	assign boundaryScanSel = tapSelect == JTS_TAP_BSCAN;
	assign debugTapSel = tapSelect == JTS_TAP_DEBUG;

	bscan_select_a: assert property (@(posedge clk)
		disable iff (!nrst)
		trstRise && emuPair == PAIR_BSCAN |=> boundaryScanSel)
		else $error("pair 01b did not select boundary scan");

	debug_route_a: assert property (@(posedge clk)
		disable iff (!nrst)
		boundaryScanSel != debugTapSel &&
		boundaryScanSel == (sampledPair == PAIR_BSCAN))
		else $error("TAP routing disagrees with sampled pair");

	zero_keeps_debug_a: assert property (@(posedge clk)
		disable iff (!nrst)
		trstRise && emuPair == PAIR_SAFE |=> debugTapSel)
		else $error("pair 00b did not keep debug TAP");

	sel_hold_a: assert property (@(posedge clk)
		disable iff (!nrst)
		!trstRise |=> $stable(tapSelect) && $stable(sampledPair))
		else $error("TAP selection changed without test reset rise");

	sample_pair_a: assert property (@(posedge clk)
		disable iff (!nrst)
		trstRise |=> sampledPair == $past(emuPair))
		else $error("sampled pair does not match pair at edge");

	// ************************************************************
	// Debug chain initialisation tracking
	// ************************************************************
	always_comb begin
		next_lowCnt = lowCnt;
		if (trstLevel) begin
			next_lowCnt = '0;
		end else if (lowCnt != LOW_CNT_W'(TRST_LOW_CYC)) begin
			next_lowCnt = lowCnt + LOW_CNT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			lowCnt <= '0;
		end else begin
			lowCnt <= next_lowCnt;
		end
	end

	// Sticky until device reset; boundary scan never waits on it
	always_ff @(posedge clk) begin
		if (!nrst) begin
			debugChainReady <= 1'b0;
		end else if (lowCnt == LOW_CNT_W'(TRST_LOW_CYC)) begin
			debugChainReady <= 1'b1;
		end
	end

	chain_ready_a: assert property (@(posedge clk)
		disable iff (!nrst)
		$rose(debugChainReady) |-> $past(!trstLevel, 2))
		else $error("debug chains ready without test reset low");

	chain_sticky_a: assert property (@(posedge clk)
		disable iff (!nrst)
		debugChainReady |=> debugChainReady)
		else $error("debug chain ready dropped");

endmodule

/* testbench/jts_debugger_model.sv */
// Purpose: External debugger driving test reset and emulation pins
// Assumes: Pins change on the falling clock edge
// Notes: Pin zero idles high as through its pull-ups
module jts_debugger_model (
	input wire logic clk,
	output logic testResetN,
	output logic emulationPinZero,
	output logic emulationPinOne
);
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// Idle levels
	// ************************************************************
	initial begin
		testResetN = 1'b0;
		emulationPinZero = 1'b1;
		emulationPinOne = 1'b0;
	end

	// ************************************************************
	// Test reset pulse with pins held across the release
	// ************************************************************
	task automatic trst_pulse(input int lowCyc, input logic [1:0] pair);
		@(negedge clk);
		testResetN = 1'b0;
		{emulationPinOne, emulationPinZero} = pair;
		repeat (lowCyc) @(negedge clk);
		testResetN = 1'b1;
		repeat (8) @(negedge clk);
	endtask

	// ************************************************************
	// Emulation pin change with test reset left alone
	// ************************************************************
	task automatic set_pins(input logic [1:0] pair);
		@(negedge clk);
		{emulationPinOne, emulationPinZero} = pair;
	endtask
endmodule

/* testbench/test_jtag_tap_select.sv */
// Purpose: Self-checking bench for the TAP selection block
// Assumes: Inputs change on the falling clock edge
// Notes: Debugger model drives test reset and emulation pins
module test_jtag_tap_select
	import jts_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic testResetN;
	logic emulationPinZero;
	logic emulationPinOne;
	jts_pad_cfg_s padCfg = '0;
	logic obsClk = 1'b0;
	logic spiFn = 1'b1;
	jts_tap_e tapSelect;
	logic boundaryScanSel;
	logic debugTapSel;
	logic debugChainReady;
	logic [1:0] sampledPair;
	logic emuOnePadOut;
	logic emuOnePadOeN;
	logic spiCs1PadOut;
	logic spiCs1PadOeN;
	int failures = 0;
	int checkCount = 0;

	always #2 clk = ~clk;

	jts_debugger_model dbg (.clk(clk), .testResetN(testResetN),
		.emulationPinZero(emulationPinZero),
		.emulationPinOne(emulationPinOne));

	jts_tap_select uut (.clk(clk), .nrst(nrst), .testResetN(testResetN),
		.emulationPinZero(emulationPinZero),
		.emulationPinOne(emulationPinOne), .padCfg(padCfg),
		.observationClockOutput(obsClk), .spiChipSelectFn(spiFn),
		.tapSelect(tapSelect), .boundaryScanSel(boundaryScanSel),
		.debugTapSel(debugTapSel), .debugChainReady(debugChainReady),
		.sampledPair(sampledPair), .emuOnePadOut(emuOnePadOut),
		.emuOnePadOeN(emuOnePadOeN), .spiCs1PadOut(spiCs1PadOut),
		.spiCs1PadOeN(spiCs1PadOeN));

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic check(input logic ok, input string msg);
		checkCount++;
		if (ok !== 1'b1) begin
			failures++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask

	task automatic expect_sel(input logic [1:0] pair, input logic bscan);
		check(sampledPair === pair, "sampled pair");
		check(boundaryScanSel === bscan, "boundary scan select");
		check(debugTapSel === !bscan, "debug select");
		check(tapSelect === jts_tap_e'(bscan), "tap select");
	endtask

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", checkCount, failures);
		if (failures == 0 && checkCount > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic scn_short_pulse();
		check({debugTapSel, debugChainReady} === 2'h2, "reset");
		dbg.trst_pulse(10, 2'h1);
		expect_sel(2'h1, 1'b1);
		check(debugChainReady === 1'b0, "ready early");
	endtask

	task automatic scn_debug_pair();
		dbg.trst_pulse(30, 2'h0);
		expect_sel(2'h0, 1'b0);
		check(debugChainReady === 1'b1, "not ready");
	endtask

	task automatic scn_hold();
		dbg.trst_pulse(30, 2'h1);
		expect_sel(2'h1, 1'b1);
		dbg.set_pins(2'h2);
		repeat (12) @(negedge clk);
		expect_sel(2'h1, 1'b1);
	endtask

	task automatic scn_pin_one_mux();
		padCfg.emuPinOnePadConfig = MODE_OBS_EMULATION_PIN_ONE;
		obsClk = 1'b1;
		dbg.trst_pulse(30, 2'h3);
		expect_sel(2'h1, 1'b1);
		check({emuOnePadOeN, emuOnePadOut} === 2'h1, "emulation_pin_one obs");
	endtask

	task automatic scn_pin_zero_modes();
		for (int m = 1; m < 16; m++) begin
			padCfg.emuPinZeroPadConfig = m[3:0];
			dbg.trst_pulse(30, 2'h1);
			expect_sel((m == 15) ? 2'h1 : 2'h0, m == 15);
		end
		padCfg.emuPinZeroPadConfig = MODE_DEFAULT;
	endtask

	task automatic scn_pads();
		padCfg.emuPinOnePadConfig = MODE_DEFAULT;
		padCfg.spiCs1PadConfig = MODE_OBS_SPI;
		repeat (2) @(negedge clk);
		check({spiCs1PadOeN, spiCs1PadOut} === 2'h1, "cs1 obs");
		check(emuOnePadOeN === 1'b1, "emulation_pin_one still driven");
		obsClk = 1'b0;
		repeat (2) @(negedge clk);
		check(spiCs1PadOut === 1'b0, "cs1 obs low");
		dbg.trst_pulse(30, 2'h3);
		expect_sel(2'h3, 1'b0);
		padCfg.spiCs1PadConfig = MODE_DEFAULT;
		spiFn = 1'b0;
		repeat (2) @(negedge clk);
		check({spiCs1PadOeN, spiCs1PadOut} === 2'h0, "cs1 fn");
		padCfg.spiCs1PadConfig = 4'h2;
		repeat (2) @(negedge clk);
		check({spiCs1PadOeN, spiCs1PadOut} === 2'h3, "cs1 idle");
	endtask

	// ************************************************************
	// Main sequence and watchdog
	// ************************************************************
	initial begin
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		scn_short_pulse();
		scn_debug_pair();
		scn_hold();
		scn_pin_one_mux();
		scn_pin_zero_modes();
		scn_pads();
		wrap_up();
	end

	initial begin
		repeat (20000) @(negedge clk);
		failures++;
		$display("Error at %0t: timeout", $time);
		wrap_up();
	end
endmodule
